// ### pkg/eacs_pkg.sv
// Summary of operation
// - tx amp line goes active while the radio needs to transmit, inactive otherwise.
// - tx amp line drives its active level only while tx_amp_enable is one.
// - tx_amp_polarity picks the active level of the tx amp line.
// - after transmitter power-up wait transmitter_settle_time microseconds before frame start.
// - after external amp power-up wait ext_amp_settle_time microseconds before frame start.
// - sequenced stages: first stage waits own transient plus other stage delay.
// - with tx amp disabled only the transmitter settle delay governs medium access.
// - frame data starts only after both tx settle intervals have elapsed.
// - rx amp line goes active while the radio needs reception, inactive otherwise.
// - rx amp line drives its active level only while rx_amp_enable is one.
// - rx_amp_polarity picks the active level of the rx amp line.
// - reception starts rx_amp_settle_time microseconds after the rx amp powers up.
// - rx amp and receiver start together; input valid after the longer transient; the code waits only rx_amp_settle_time.
// - radio_state reports 111 tx+amp, 110 rx+amp, 101 synth+amp, read only.
package eacs_pkg;

  localparam logic [7:0] EACS_ADDR_STATUS   = 8'h02;
  localparam logic [7:0] EACS_ADDR_TX_SETTLE = 8'h3c;
  localparam logic [7:0] EACS_ADDR_TX_AMP   = 8'h3d;
  localparam logic [7:0] EACS_ADDR_RX_AMP   = 8'h3e;

  localparam int EACS_POL_BIT = 6;
  localparam int EACS_EN_BIT  = 5;

  localparam logic [4:0] EACS_TX_SETTLE_RST = 5'h03;
  localparam logic [4:0] EACS_EXT_SETTLE_RST = 5'h04;
  localparam logic [4:0] EACS_RX_SETTLE_RST = 5'h04;

  localparam logic [2:0] EACS_ST_TX_AMP    = 3'h7;
  localparam logic [2:0] EACS_ST_RX_AMP    = 3'h6;
  localparam logic [2:0] EACS_ST_SYNTH_AMP = 3'h5;
  localparam logic [2:0] EACS_ST_OTHER     = 3'h0;

  // 1 us tick from the 40 MHz clock
  localparam int CLK_HZ          = 40000000;
  localparam int TICK_NS         = 1000;
  localparam int TICK_CYCLES     = TICK_NS / (1000000000 / CLK_HZ);
  localparam logic [5:0] EACS_TICK_LAST = 6'(TICK_CYCLES - 1);

  typedef struct packed {
    logic       polarity;
    logic       enable;
    logic [4:0] settle;
  } eacs_amp_cfg_t;

endpackage : eacs_pkg

// ### hdl/eacs_settle_timer.sv
`timescale 1ns/1ps
// down counter of microsecond ticks, loaded at stage power-up
module eacs_settle_timer (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [5:0] load_val,
  input  wire logic       active,
  output logic            done
);
  logic [5:0] cnt_q;
  logic       run_q;

  // load on start; counts only while the stage stays powered
  always_ff @(posedge sys_clk) begin
    if (reset || !active) begin
      cnt_q <= 6'h00;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= load_val;
      run_q <= 1'b1;
    end else if (run_q && tick && cnt_q != 6'h00) begin
      cnt_q <= cnt_q - 6'h01;
    end
  end

  assign done = run_q && !start && (cnt_q == 6'h00);

  property p_done_needs_zero;
    @(posedge sys_clk) disable iff (reset)
      done |-> cnt_q == 6'h00;
  endproperty
  a_done_needs_zero: assert property (p_done_needs_zero) else $error("settle done early");
endmodule : eacs_settle_timer

// ### hdl/eacs_amp_ctrl.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module eacs_amp_ctrl (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       tx_need,
  input  wire logic       tx_amp_first,
  input  wire logic       rx_need,
  input  wire logic       synth_on,
  output logic            tx_amp_line,
  output logic            rx_amp_line,
  output logic            tx_access_ok,
  output logic            rx_valid
);
  logic [4:0]          tx_settle_q;
  eacs_pkg::eacs_amp_cfg_t tx_cfg_q;
  eacs_pkg::eacs_amp_cfg_t rx_cfg_q;
  logic [5:0]          tick_cnt_q;
  logic                tick_q;
  logic                tx_need_q;
  logic                rx_need_q;
  logic                tx_amp_line_q;
  logic                rx_amp_line_q;
  logic                tx_access_q;
  logic                rx_valid_q;
  logic [2:0]          radio_state_q;
  logic [7:0]          rdata_q;

  // register write decode
  wire wr_tx_settle = reg_wr && reg_addr == eacs_pkg::EACS_ADDR_TX_SETTLE;
  wire wr_tx_amp    = reg_wr && reg_addr == eacs_pkg::EACS_ADDR_TX_AMP;
  wire wr_rx_amp    = reg_wr && reg_addr == eacs_pkg::EACS_ADDR_RX_AMP;

  // writes keep bit 7 out; it has no storage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_settle_q <= eacs_pkg::EACS_TX_SETTLE_RST;
      tx_cfg_q    <= '{1'b0, 1'b0, eacs_pkg::EACS_EXT_SETTLE_RST};
      rx_cfg_q    <= '{1'b0, 1'b0, eacs_pkg::EACS_RX_SETTLE_RST};
    end else begin
      if (wr_tx_settle) tx_settle_q <= reg_wdata[4:0];
      if (wr_tx_amp) tx_cfg_q <= reg_wdata[6:0];
      if (wr_rx_amp) rx_cfg_q <= reg_wdata[6:0];
    end
  end

  // 1 us tick generator
  always_ff @(posedge sys_clk) begin
    if (reset || tick_cnt_q == eacs_pkg::EACS_TICK_LAST) tick_cnt_q <= 6'h00;
    else tick_cnt_q <= tick_cnt_q + 6'h01;
    tick_q <= !reset && tick_cnt_q == eacs_pkg::EACS_TICK_LAST;
  end

  // power-up edges of each stage
  wire tx_rise = tx_need && !tx_need_q;
  wire rx_rise = rx_need && !rx_need_q;
  wire tx_en   = tx_cfg_q.enable;
  wire rx_en   = rx_cfg_q.enable;

  // sequenced: the first stage adds the other stage's delay
  wire [5:0] tx_load = (tx_en && !tx_amp_first) ?
                       6'(tx_settle_q) + 6'(tx_cfg_q.settle) : 6'(tx_settle_q);
  wire [5:0] pa_load = tx_amp_first ?
                       6'(tx_cfg_q.settle) + 6'(tx_settle_q) : 6'(tx_cfg_q.settle);
  wire [5:0] rx_load = 6'(rx_cfg_q.settle);

  logic tx_done;
  logic pa_done;
  logic rx_done;

  eacs_settle_timer u_tx_timer (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .tick     (tick_q),
    .start    (tx_rise),
    .load_val (tx_load),
    .active   (tx_need),
    .done     (tx_done)
  );

  eacs_settle_timer u_pa_timer (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .tick     (tick_q),
    .start    (tx_rise && tx_en),
    .load_val (pa_load),
    .active   (tx_need && tx_en),
    .done     (pa_done)
  );

  eacs_settle_timer u_rx_timer (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .tick     (tick_q),
    .start    (rx_rise),
    .load_val (rx_load),
    .active   (rx_need && rx_en),
    .done     (rx_done)
  );

  // frame may start only when every live stage has settled
  wire tx_ok_d = tx_need && tx_done && (!tx_en || pa_done);
  // receiver transient is covered by the caller; amp delay extends it
  wire rx_ok_d = rx_need && (!rx_en || rx_done);

  // line levels: active = polarity bit, inactive = its inverse
  wire tx_line_d = (tx_need && tx_en) ? tx_cfg_q.polarity
                                      : !tx_cfg_q.polarity;
  wire rx_line_d = (rx_need && rx_en) ? rx_cfg_q.polarity
                                      : !rx_cfg_q.polarity;

  // radio state, transmit has priority over receive
  wire [2:0] state_d = (tx_need && tx_en) ? eacs_pkg::EACS_ST_TX_AMP :
                       (rx_need && rx_en) ? eacs_pkg::EACS_ST_RX_AMP :
                       (synth_on && (tx_en || rx_en)) ? eacs_pkg::EACS_ST_SYNTH_AMP :
                       eacs_pkg::EACS_ST_OTHER;

  // read mux; unmapped reads return zero
  wire [7:0] rdata_d =
    reg_addr == eacs_pkg::EACS_ADDR_STATUS    ? {5'h00, radio_state_q} :
    reg_addr == eacs_pkg::EACS_ADDR_TX_SETTLE ? {3'h0, tx_settle_q} :
    reg_addr == eacs_pkg::EACS_ADDR_TX_AMP    ? {1'b0, tx_cfg_q} :
    reg_addr == eacs_pkg::EACS_ADDR_RX_AMP    ? {1'b0, rx_cfg_q} : 8'h00;

  // output flops; lines reset to inactive-high for default polarity zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_need_q     <= 1'b0;
      rx_need_q     <= 1'b0;
      tx_amp_line_q <= 1'b1;
      rx_amp_line_q <= 1'b1;
      tx_access_q   <= 1'b0;
      rx_valid_q    <= 1'b0;
      radio_state_q <= eacs_pkg::EACS_ST_OTHER;
      rdata_q       <= 8'h00;
    end else begin
      tx_need_q     <= tx_need;
      rx_need_q     <= rx_need;
      tx_amp_line_q <= tx_line_d;
      rx_amp_line_q <= rx_line_d;
      tx_access_q   <= tx_ok_d;
      rx_valid_q    <= rx_ok_d;
      radio_state_q <= state_d;
      rdata_q       <= reg_rd ? rdata_d : 8'h00;
    end
  end

  assign tx_amp_line  = tx_amp_line_q;
  assign rx_amp_line  = rx_amp_line_q;
  assign tx_access_ok = tx_access_q;
  assign rx_valid     = rx_valid_q;
  assign reg_rdata    = rdata_q;

  property p_tx_line;
    @(posedge sys_clk) disable iff (reset)
      tx_need && tx_en |=> tx_amp_line == $past(tx_cfg_q.polarity);
  endproperty
  a_tx_line: assert property (p_tx_line) else $error("tx line not active");

  property p_tx_off;
    @(posedge sys_clk) disable iff (reset)
      !tx_en |=> tx_amp_line != $past(tx_cfg_q.polarity);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx line active while disabled");

  property p_rx_line;
    @(posedge sys_clk) disable iff (reset)
      rx_need && rx_en |=> rx_amp_line == $past(rx_cfg_q.polarity);
  endproperty
  a_rx_line: assert property (p_rx_line) else $error("rx line not active");

  property p_rx_off;
    @(posedge sys_clk) disable iff (reset)
      !rx_need |=> rx_amp_line != $past(rx_cfg_q.polarity);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx line active while idle");

  property p_tx_wait;
    @(posedge sys_clk) disable iff (reset)
      tx_rise && tx_settle_q != 5'h00 |=> !tx_access_ok [*2];
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("frame start too early");

  property p_rx_wait;
    @(posedge sys_clk) disable iff (reset)
      rx_rise && rx_en && rx_cfg_q.settle > 5'h01 |=> !rx_valid [*8];
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("rx valid too early");

  property p_state_tx;
    @(posedge sys_clk) disable iff (reset)
      tx_need && tx_en |=> radio_state_q == eacs_pkg::EACS_ST_TX_AMP;
  endproperty
  a_state_tx: assert property (p_state_tx) else $error("wrong radio state");

  property p_rd_resv;
    @(posedge sys_clk) disable iff (reset)
      reg_rd |=> reg_rdata[7] == 1'b0;
  endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("reserved bit read as one");

  property p_tx_only;
    @(posedge sys_clk) disable iff (reset)
      tx_need && !tx_en && tx_done |=> tx_access_ok;
  endproperty
  a_tx_only: assert property (p_tx_only) else $error("tx access not granted");

  // rx line must stay inactive whenever the rx amp is disabled
  property p_rx_dis;
    @(posedge sys_clk) disable iff (reset)
      !rx_en |=> rx_amp_line != $past(rx_cfg_q.polarity);
  endproperty
  a_rx_dis: assert property (p_rx_dis) else $error("rx line active while disabled");

  property p_tx_idle;
    @(posedge sys_clk) disable iff (reset)
      !tx_need |=> tx_amp_line != $past(tx_cfg_q.polarity);
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx line active while idle");

  // access drops as soon as the transmit need goes away
  property p_tx_drop;
    @(posedge sys_clk) disable iff (reset)
      !tx_need |=> !tx_access_ok;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("tx access without need");

  // an unsettled external amp blocks the frame start
  property p_pa_block;
    @(posedge sys_clk) disable iff (reset)
      tx_need && tx_en && !pa_done |=> !tx_access_ok;
  endproperty
  a_pa_block: assert property (p_pa_block) else $error("frame start before amp settled");

  property p_rx_drop;
    @(posedge sys_clk) disable iff (reset)
      !rx_need |=> !rx_valid;
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx valid without need");

  property p_state_rx;
    @(posedge sys_clk) disable iff (reset)
      rx_need && rx_en && !(tx_need && tx_en) |=> radio_state_q == eacs_pkg::EACS_ST_RX_AMP;
  endproperty
  a_state_rx: assert property (p_state_rx) else $error("wrong rx radio state");

  property p_state_synth;
    @(posedge sys_clk) disable iff (reset)
      synth_on && (tx_en || rx_en) && !(tx_need && tx_en) && !(rx_need && rx_en)
        |=> radio_state_q == eacs_pkg::EACS_ST_SYNTH_AMP;
  endproperty
  a_state_synth: assert property (p_state_synth) else $error("wrong synth state");

  // tick is a single-cycle pulse
  property p_tick_pulse;
    @(posedge sys_clk) disable iff (reset)
      tick_q |=> !tick_q;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");

  // read data stands only in the cycle after a read strobe
  property p_rdata_idle;
    @(posedge sys_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

  c_tx_frame: cover property (@(posedge sys_clk) tx_en && tx_rise ##[1:200] tx_access_ok);
  c_rx_valid: cover property (@(posedge sys_clk) rx_en && rx_rise ##[1:200] rx_valid);
  c_synth:    cover property (@(posedge sys_clk) radio_state_q == eacs_pkg::EACS_ST_SYNTH_AMP);
endmodule : eacs_amp_ctrl

// ### testbench/eacs_amp_model.sv
`timescale 1ns/1ps
// external amplifier stand-in: powered when its pin shows the active level
module eacs_amp_model (
  input  wire logic ctrl_line,
  input  wire logic active_high,
  output logic      amp_on
);
  // exact match so a floating pin never counts as powered
  assign amp_on = (ctrl_line === active_high);
endmodule : eacs_amp_model

// ### testbench/eacs_amp_ctrl_bench.sv
`timescale 1ns/1ps
module eacs_amp_ctrl_bench;
  logic       sys_clk      = 1'b0;
  logic       reset        = 1'b1;
  logic [7:0] reg_addr     = 8'h00;
  logic [7:0] reg_wdata    = 8'h00;
  logic       reg_wr       = 1'b0;
  logic       reg_rd       = 1'b0;
  logic       tx_need      = 1'b0;
  logic       tx_amp_first = 1'b0;
  logic       rx_need      = 1'b0;
  logic       synth_on     = 1'b0;
  logic       pol          = 1'b0;
  logic       en           = 1'b0;
  logic [7:0] reg_rdata;
  logic       tx_amp_line, rx_amp_line, tx_access_ok, rx_valid, tx_amp_on, rx_amp_on;
  int         errors       = 0;
  int         n_checks     = 0;
  int         cycles       = 0;
  int         tx_set, ext_set;

  always #12.5 sys_clk = ~sys_clk;

  eacs_amp_ctrl u_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_need(tx_need), .tx_amp_first(tx_amp_first), .rx_need(rx_need), .synth_on(synth_on),
    .tx_amp_line(tx_amp_line), .rx_amp_line(rx_amp_line), .tx_access_ok(tx_access_ok),
    .rx_valid(rx_valid));
  eacs_amp_model u_tx_amp (.ctrl_line(tx_amp_line), .active_high(pol), .amp_on(tx_amp_on));
  eacs_amp_model u_rx_amp (.ctrl_line(rx_amp_line), .active_high(pol), .amp_on(rx_amp_on));

  // hang guard, a few times the longest expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 check("reg_rdata", reg_rdata, exp);
  endtask : rdc

  // free-running tick may shorten the wait by up to one microsecond
  task automatic wait_flag(input bit rx, input int us);
    int n;
    n = 0;
    while ((rx ? rx_valid : tx_access_ok) !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check("settle_cycles", 8'(n >= (us - 1) * 40 && n <= us * 40 + 4), 8'h01);
  endtask : wait_flag

  task automatic summarize();
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // main sequence: reset values, refusals, then tx and rx over all enable/polarity mixes
  initial begin
    void'($urandom(37378));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(eacs_pkg::EACS_ADDR_STATUS, 8'h00);
    rdc(eacs_pkg::EACS_ADDR_TX_SETTLE, 8'h03);
    rdc(eacs_pkg::EACS_ADDR_TX_AMP, 8'h04);
    rdc(eacs_pkg::EACS_ADDR_RX_AMP, 8'h04);
    rdc(8'h10, 8'h00);
    check("tx_amp_line", tx_amp_line, 8'h01);
    wr(eacs_pkg::EACS_ADDR_TX_AMP, 8'h62);
    rdc(eacs_pkg::EACS_ADDR_TX_AMP, 8'h62);
    wr(eacs_pkg::EACS_ADDR_STATUS, 8'hff);
    rdc(eacs_pkg::EACS_ADDR_STATUS, 8'h00);
    for (int k = 0; k < 4; k++) begin
      tx_set  = $urandom_range(1, 6);
      ext_set = $urandom_range(1, 6);
      wr(eacs_pkg::EACS_ADDR_TX_SETTLE, 8'(tx_set));
      wr(eacs_pkg::EACS_ADDR_TX_AMP, {1'b0, k[0], k[1], 5'(ext_set)});
      wr(eacs_pkg::EACS_ADDR_RX_AMP, {1'b0, k[0], k[1], 5'(tx_set)});
      pol          <= k[0];
      en           <= k[1];
      tx_need      <= 1'b1;
      tx_amp_first <= 1'($urandom_range(0, 1));
      wait_flag(1'b0, k[1] ? tx_set + ext_set : tx_set);
      check("tx_amp_on", tx_amp_on, 8'(en));
      rdc(eacs_pkg::EACS_ADDR_STATUS, en ? 8'h07 : 8'h00);
      tx_need <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 check("tx_off", {tx_amp_on, tx_access_ok}, 8'h00);
      rx_need <= 1'b1;
      wait_flag(1'b1, k[1] ? tx_set : 0);
      check("rx_amp_on", rx_amp_on, 8'(en));
      rdc(eacs_pkg::EACS_ADDR_STATUS, en ? 8'h06 : 8'h00);
      rx_need <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 check("rx_off", {rx_amp_on, rx_valid}, 8'h00);
    end
    synth_on <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdc(eacs_pkg::EACS_ADDR_STATUS, 8'h05);
    synth_on <= 1'b0;
    summarize();
  end
endmodule : eacs_amp_ctrl_bench
